// ---- include/usr_pkg.sv ----
// What this block does
// - idle 3 ms sets suspend flag, interrupt
// - any clock gate write gates clock, PHY
// - wake request with resume enable times 5 ms idle, self-clears
// - device resume flag readable in status
// - resume bit held drives remote wake-up
// - force J bit drives Data J state
// - suspended, Data K raises resume interrupt
// - PLL seen after host resume clears flag
// - host resume detected even in stop mode
// - separate resume and general interrupt outputs
// - resume enable selects which resumes interrupt
// - each source has request and enable bit
// - identification reports source by fixed priority
// - two DMA channels select any endpoint buffer
// - one data port, address increments 0..63
// - buffer address resets when request asserts
// - launch asserts request until done or an access past byte 63
//
// Purpose: constants and types of the usb suspend, interrupt and dma block
// Assumes: one 100 MHz clock, byte wide registers on a 32-bit bus word
// Notes: register indices times four give the byte addresses
package usr_pkg;
   localparam int CLOCK_MHZ = 100;
   localparam int SUSPEND_IDLE_MS = 3;
   localparam int WAKE_IDLE_MS = 5;
   localparam int SUSPEND_CYCLES = SUSPEND_IDLE_MS * 1000 * CLOCK_MHZ;
   localparam int WAKE_CYCLES = WAKE_IDLE_MS * 1000 * CLOCK_MHZ;
   localparam int IDLE_W = 20;
   localparam int NUM_EP = 4;
   localparam int BUF_BYTES = 64;
   localparam int PTR_W = 6;
   localparam int NUM_SRC = 3 + 2 * NUM_EP;

   // register indices on the bus
   localparam logic [11:0] IDX_SUB_ADDR = 12'hF59;
   localparam logic [11:0] IDX_SUB_DATA = 12'hF5A;
   localparam logic [11:0] IDX_DMA0_CTL = 12'hF5C;
   localparam logic [11:0] IDX_DMA1_CTL = 12'hF5D;
   localparam logic [11:0] IDX_DMA_DATA = 12'hF5E;
   localparam logic [11:0] IDX_IRQ_CTL = 12'hF5F;

   // subregister addresses behind the subaddress register
   localparam logic [6:0] SUB_CLK_GATE = 7'h10;
   localparam logic [6:0] SUB_IID = 7'h28;
   localparam logic [6:0] SUB_IN_REQ = 7'h29;
   localparam logic [6:0] SUB_OUT_REQ = 7'h2A;
   localparam logic [6:0] SUB_PROTO_REQ = 7'h2B;
   localparam logic [6:0] SUB_IN_EN = 7'h2C;
   localparam logic [6:0] SUB_OUT_EN = 7'h2D;
   localparam logic [6:0] SUB_PROTO_EN = 7'h2E;
   localparam logic [6:0] SUB_CTRL_STAT = 7'h56;

   // bit positions
   localparam int PR_SUSPEND = 0;
   localparam int PR_SOF = 1;
   localparam int PR_BUS_RESET = 2;
   localparam int IC_RESUME_EN = 0;
   localparam int IC_WAKE = 1;
   localparam int IC_RESUME_PEND = 2;
   localparam int CS_SIG_RESUME = 0;
   localparam int CS_FORCE_J = 1;
   localparam int CS_DEV_RESUME = 2;
   localparam int CS_DISCONNECT_BIT = 3;
   localparam int DC_DIR_IN = 2;
   localparam int DC_LAUNCH = 3;
   localparam int DC_BUSY = 7;

   typedef enum logic [1:0] {PS_ACTIVE, PS_SUSPENDED, PS_HOST_WAKE} usr_pwr_t;

   // one differential line pair
   typedef struct packed {
      logic dp;
      logic dm;
   } usr_pins_t;

   // what the line monitor reports
   typedef struct packed {
      logic idle;
      logic k_state;
      logic pll_ok;
      logic [IDLE_W-1:0] idle_cnt;
   } usr_mon_t;
endpackage

// ---- core/usr_line_mon.sv ----
// Purpose: synchronises the bus pair and pll lock, times continuous idle
// Assumes: full speed line, idle is J (dp high, dm low)
// Notes: idle count saturates so a threshold match fires once per idle run
`timescale 1ns/10ps
module usr_line_mon (
   input wire logic clock,
   input wire logic rst_b,
   input wire usr_pkg::usr_pins_t line_in,
   input wire logic pll_lock,
   output usr_pkg::usr_mon_t mon
);
   import usr_pkg::*;

   typedef struct packed {
      logic [2:0] meta;
      logic [2:0] sync;
      logic [IDLE_W-1:0] cnt;
   } usr_mon_st_t;

   usr_mon_st_t st;
   usr_mon_st_t next_st;
   logic idle;

   // the first stage feeds only the second stage
   assign idle = st.sync[2] && !st.sync[1];

   // idle run length, restarted by any non-idle sample
   always_comb begin
      next_st = st;
      next_st.meta = {line_in.dp, line_in.dm, pll_lock};
      next_st.sync = st.meta;
      if (!idle) begin
         next_st.cnt = '0;
      end else if (st.cnt != {IDLE_W{1'b1}}) begin
         next_st.cnt = st.cnt + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // one driver for the whole report: idle, k state, pll seen, idle count
   assign mon = {idle, !st.sync[2] && st.sync[1], st.sync[0], st.cnt};
endmodule

// ---- core/usr_core.sv ----
// Purpose: suspend and resume control, interrupt merge and dma data port
// Assumes: avalon slave with byte data in lane 0, core events on this clock
// Notes: every access takes two cycles; dma port stalls while core writes
`timescale 1ns/10ps
module usr_core #(
   parameter int SUSPEND_CNT = usr_pkg::SUSPEND_CYCLES,
   parameter int WAKE_CNT = usr_pkg::WAKE_CYCLES
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [13:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire usr_pkg::usr_pins_t line_in,
   output usr_pkg::usr_pins_t line_out,
   output logic line_oe,
   input wire logic pll_lock,
   input wire logic [usr_pkg::NUM_EP-1:0] in_ep_event,
   input wire logic [usr_pkg::NUM_EP-1:0] out_ep_event,
   input wire logic sof_event,
   input wire logic bus_reset_event,
   input wire logic core_wr,
   input wire logic [8:0] core_addr,
   input wire logic [7:0] core_wdata,
   input wire logic [1:0] dma_done,
   output logic [1:0] dma_req,
   output logic usb_irq,
   output logic resume_irq,
   output logic phy_power_down,
   output logic usb_clk_enable,
   output logic disconnect
);
   import usr_pkg::*;

   typedef struct packed {
      logic ack;
      logic [7:0] rdata;
      logic [6:0] sub_addr;
      logic [NUM_EP-1:0] in_req;
      logic [NUM_EP-1:0] out_req;
      logic [2:0] proto_req;
      logic [NUM_EP-1:0] in_en;
      logic [NUM_EP-1:0] out_en;
      logic [2:0] proto_en;
      logic resume_en;
      logic wake;
      logic resume_pend;
      logic sig_resume;
      logic force_j;
      logic dev_resume;
      logic disconnect_bit;
      logic gated;
      usr_pwr_t pwr;
      logic [IDLE_W-1:0] wake_cnt;
      logic [1:0] req;
      logic [1:0][2:0] sel;
      logic [1:0][PTR_W-1:0] ptr;
      logic [1:0][PTR_W:0] cnt;
   } usr_core_st_t;

   usr_core_st_t st;
   usr_core_st_t next_st;
   usr_mon_t mon;
   logic [7:0] buf_mem [0:2*NUM_EP*BUF_BYTES-1];
   logic req_in;
   logic acc;
   logic wr_acc;
   logic data_hit;
   logic dma_ch;
   logic [8:0] dma_addr;
   logic [NUM_SRC-1:0] active;
   logic [7:0] bus_wd;

   // lowest index wins: suspend, sof, bus reset, then out, then in endpoints
   function automatic logic [7:0] src_code(input logic [NUM_SRC-1:0] act);
      logic [7:0] code;
      code = 8'h00;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (act[i]) begin
            code = 8'(i + 1);
         end
      end
      return code;
   endfunction

   // register hit test on a word aligned byte address
   function automatic logic hit(input logic [13:0] a, input logic [11:0] idx);
      return (a[1:0] == 2'h0) && (a[13:2] == idx);
   endfunction

   usr_line_mon u_mon (
      .clock(clock),
      .rst_b(rst_b),
      .line_in(line_in),
      .pll_lock(pll_lock),
      .mon(mon)
   );

   // bus handshake: request seen, one wait cycle, accepted on ack
   assign req_in = (read || write);
   assign data_hit = hit(address, IDX_DMA_DATA);
   // a core write in the accepting cycle stalls again, so no port write is lost
   assign acc = req_in && st.ack && !(core_wr && data_hit);
   assign wr_acc = acc && write && byteenable[0];
   assign waitrequest = req_in && !acc;
   assign bus_wd = writedata[7:0];
   assign dma_ch = !st.req[0];
   assign dma_addr = {st.sel[dma_ch], st.ptr[dma_ch]};
   assign active = {st.in_req & st.in_en, st.out_req & st.out_en, st.proto_req & st.proto_en};

   always_comb begin
      next_st = st;
      // a core write to the buffer holds off a data port access and restarts its wait cycle
      next_st.ack = req_in && !acc && !(core_wr && data_hit);

      // read data captured one edge before the accepting edge
      if (req_in && !st.ack) begin
         next_st.rdata = 8'h00;
         if (hit(address, IDX_SUB_ADDR)) begin
            next_st.rdata = {1'b0, st.sub_addr};
         end else if (hit(address, IDX_IRQ_CTL)) begin
            next_st.rdata[IC_RESUME_EN] = st.resume_en;
            next_st.rdata[IC_WAKE] = st.wake;
            next_st.rdata[IC_RESUME_PEND] = st.resume_pend;
         end else if (hit(address, IDX_DMA0_CTL) || hit(address, IDX_DMA1_CTL)) begin
            next_st.rdata[2:0] = st.sel[address[2]];
            next_st.rdata[DC_BUSY] = st.req[address[2]];
         end else if (data_hit && (st.req != 2'h0)) begin
            next_st.rdata = buf_mem[dma_addr];
         end else if (hit(address, IDX_SUB_DATA)) begin
            case (st.sub_addr)
               SUB_IID: next_st.rdata = src_code(active);
               SUB_IN_REQ: next_st.rdata = 8'(st.in_req);
               SUB_OUT_REQ: next_st.rdata = 8'(st.out_req);
               SUB_PROTO_REQ: next_st.rdata = 8'(st.proto_req);
               SUB_IN_EN: next_st.rdata = 8'(st.in_en);
               SUB_OUT_EN: next_st.rdata = 8'(st.out_en);
               SUB_PROTO_EN: next_st.rdata = 8'(st.proto_en);
               SUB_CTRL_STAT: begin
                  next_st.rdata[CS_SIG_RESUME] = st.sig_resume;
                  next_st.rdata[CS_FORCE_J] = st.force_j;
                  next_st.rdata[CS_DEV_RESUME] = st.dev_resume;
                  next_st.rdata[CS_DISCONNECT_BIT] = st.disconnect_bit;
               end
               default: next_st.rdata = 8'h00;
            endcase
         end
      end

      // software writes; flag clears go first so hardware sets below win
      if (wr_acc) begin
         if (hit(address, IDX_SUB_ADDR)) begin
            next_st.sub_addr = bus_wd[6:0];
         end else if (hit(address, IDX_IRQ_CTL)) begin
            next_st.resume_en = bus_wd[IC_RESUME_EN];
            next_st.wake = bus_wd[IC_WAKE];
            if (bus_wd[IC_WAKE] && !st.wake) begin
               next_st.dev_resume = 1'b1;
               next_st.gated = 1'b0;
            end
            if (bus_wd[IC_RESUME_PEND]) begin
               next_st.resume_pend = 1'b0;
            end
         end else if (hit(address, IDX_SUB_DATA)) begin
            case (st.sub_addr)
               SUB_CLK_GATE: next_st.gated = 1'b1;
               SUB_IN_REQ: next_st.in_req = st.in_req & ~bus_wd[NUM_EP-1:0];
               SUB_OUT_REQ: next_st.out_req = st.out_req & ~bus_wd[NUM_EP-1:0];
               SUB_PROTO_REQ: next_st.proto_req = st.proto_req & ~bus_wd[2:0];
               SUB_IN_EN: next_st.in_en = bus_wd[NUM_EP-1:0];
               SUB_OUT_EN: next_st.out_en = bus_wd[NUM_EP-1:0];
               SUB_PROTO_EN: next_st.proto_en = bus_wd[2:0];
               SUB_CTRL_STAT: begin
                  next_st.sig_resume = bus_wd[CS_SIG_RESUME];
                  next_st.force_j = bus_wd[CS_FORCE_J];
                  next_st.disconnect_bit = bus_wd[CS_DISCONNECT_BIT];
               end
               default: next_st.sub_addr = st.sub_addr;
            endcase
         end
      end

      // dma channel control and data port; a relaunch beats a done pulse
      for (int c = 0; c < 2; c++) begin
         if (st.req[c] && dma_done[c]) begin
            next_st.req[c] = 1'b0;
         end
         if (wr_acc && hit(address, c[0] ? IDX_DMA1_CTL : IDX_DMA0_CTL)) begin
            next_st.sel[c] = {bus_wd[DC_DIR_IN], bus_wd[1:0]};
            if (bus_wd[DC_LAUNCH]) begin
               next_st.req[c] = 1'b1;
               next_st.ptr[c] = '0;
               next_st.cnt[c] = '0;
            end
         end
      end
      if (acc && data_hit && (st.req != 2'h0)) begin
         if (st.cnt[dma_ch] == (PTR_W + 1)'(BUF_BYTES)) begin
            next_st.req[dma_ch] = 1'b0;
         end else begin
            next_st.ptr[dma_ch] = st.ptr[dma_ch] + 1'b1;
            next_st.cnt[dma_ch] = st.cnt[dma_ch] + 1'b1;
         end
      end

      // endpoint and protocol events set sticky requests
      next_st.in_req = next_st.in_req | in_ep_event;
      next_st.out_req = next_st.out_req | out_ep_event;
      next_st.proto_req[PR_SOF] = next_st.proto_req[PR_SOF] | sof_event;
      next_st.proto_req[PR_BUS_RESET] = next_st.proto_req[PR_BUS_RESET] | bus_reset_event;

      // device timed wake-up: only runs with resume interrupts enabled
      if (st.wake && st.resume_en && mon.idle) begin
         next_st.wake_cnt = st.wake_cnt + 1'b1;
         if (st.wake_cnt == IDLE_W'(WAKE_CNT - 1)) begin
            next_st.resume_pend = 1'b1;
            next_st.wake = 1'b0;
            next_st.wake_cnt = '0;
            next_st.pwr = PS_ACTIVE;
         end
      end else begin
         next_st.wake_cnt = '0;
      end

      // power state; host resume seen without the clock gate in the path
      case (st.pwr)
         PS_ACTIVE: begin
            if (mon.idle && mon.idle_cnt == IDLE_W'(SUSPEND_CNT)) begin
               next_st.proto_req[PR_SUSPEND] = 1'b1;
               next_st.pwr = PS_SUSPENDED;
            end
         end
         PS_SUSPENDED: begin
            if (mon.k_state && !line_oe) begin
               next_st.resume_pend = 1'b1;
               next_st.gated = 1'b0;
               next_st.pwr = PS_HOST_WAKE;
            end
         end
         PS_HOST_WAKE: begin
            if (mon.pll_ok) begin
               next_st.dev_resume = 1'b0;
               if (st.resume_en) begin
                  next_st.resume_pend = 1'b1;
               end
               next_st.pwr = PS_ACTIVE;
            end
         end
         default: next_st.pwr = PS_ACTIVE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // endpoint buffers; core side has priority, the bus side was stalled
   always_ff @(posedge clock) begin
      if (core_wr) begin
         buf_mem[core_addr] <= core_wdata;
      end else if (wr_acc && data_hit && (st.req != 2'h0) && (st.cnt[dma_ch] != (PTR_W + 1)'(BUF_BYTES))) begin
         // an overrun attempt is refused and must not land in the buffer
         buf_mem[dma_addr] <= bus_wd;
      end
   end

   // resume signalling wins over forced J when both are set
   always_comb begin
      line_oe = st.sig_resume || st.force_j;
      line_out.dp = !st.sig_resume && st.force_j;
      line_out.dm = st.sig_resume;
   end

   assign readdata = {24'h000000, st.rdata};
   assign usb_irq = (active != '0);
   assign resume_irq = st.resume_pend;
   assign phy_power_down = st.gated;
   assign usb_clk_enable = !st.gated;
   assign dma_req = st.req;
   assign disconnect = st.disconnect_bit;

   default clocking dc @(posedge clock); endclocking
   default disable iff (!rst_b);

   suspend_flag_a: assert property (st.pwr == PS_ACTIVE && mon.idle && mon.idle_cnt == IDLE_W'(SUSPEND_CNT)
      |=> st.proto_req[PR_SUSPEND] && st.pwr == PS_SUSPENDED) else $error("suspend not flagged");
   clock_gate_a: assert property (wr_acc && hit(address, IDX_SUB_DATA) && st.sub_addr == SUB_CLK_GATE
      |=> phy_power_down && !usb_clk_enable) else $error("clock gate write ignored");
   wake_timer_a: assert property (st.wake && st.resume_en && mon.idle && st.wake_cnt == IDLE_W'(WAKE_CNT - 1)
      |=> !st.wake && resume_irq) else $error("wake timing end missed");
   resume_drive_a: assert property (st.sig_resume |-> line_oe && !line_out.dp && line_out.dm)
      else $error("resume not driven as K");
   force_j_a: assert property ($rose(st.force_j) && !st.sig_resume |-> line_oe && line_out.dp && !line_out.dm)
      else $error("force J not driven");
   host_resume_a: assert property (st.pwr == PS_SUSPENDED && mon.k_state && !line_oe
      |=> resume_irq && st.pwr == PS_HOST_WAKE) else $error("host resume missed");
   pll_seen_a: assert property (st.pwr == PS_HOST_WAKE && mon.pll_ok |=> !st.dev_resume ##0 (resume_irq ||
      !$past(st.resume_en))) else $error("pll recognition wrong");
   dma_launch_a: assert property (wr_acc && hit(address, IDX_DMA0_CTL) && bus_wd[DC_LAUNCH]
      |=> dma_req[0] && st.ptr[0] == '0) else $error("dma launch wrong");
   dma_overrun_a: assert property (acc && data_hit && st.req[0] && st.cnt[0] == (PTR_W + 1)'(BUF_BYTES)
      |=> !dma_req[0]) else $error("dma overrun not dropped");
   bus_answer_a: assert property (req_in && !st.ack && !(core_wr && data_hit)
      |=> !waitrequest || (core_wr && data_hit)) else $error("bus answer late");
   port_stall_a: assert property (req_in && core_wr && data_hit |-> waitrequest)
      else $error("port accepted during core write");
endmodule

// ---- tb/usr_host_model.sv ----
// Purpose: host side of the bus pair for the usr_core bench
// Assumes: mode 0 idle J, 1 resume K, 2 traffic (J and SE0 alternating)
// Notes: traffic never shows K, so a suspended device is not woken by it
`timescale 1ns/10ps
module usr_host_model (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [1:0] mode,
   input wire usr_pkg::usr_pins_t line_out,
   input wire logic line_oe,
   output usr_pkg::usr_pins_t line_in
);
   import usr_pkg::*;
   logic phase;
   usr_pins_t host;
   // traffic phase flips every cycle so idle never lasts
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         phase <= 1'b0;
      end else begin
         phase <= ~phase;
      end
   end
   // host drive per mode
   always_comb begin
      case (mode)
         2'd0: host = 2'b10;
         2'd1: host = 2'b01;
         default: host = {phase, 1'b0};
      endcase
   end
   // wire level: device drive wins while its enable is up
   assign line_in = line_oe ? line_out : host;
endmodule

// ---- tb/usr_core_bench.sv ----
// Purpose: self-checking bench of usr_core
// Assumes: shortened suspend and wake counts, host model on the pins
// Notes: reads are checked by a monitor against a queue of expectations
`timescale 1ns/10ps
module usr_core_bench;
   import usr_pkg::*;
   localparam int SUS = 40;
   localparam int WK = 60;
   localparam int LIMIT = 20000;
   logic clock, rst_b, read, write, pll_lock, sof_event, bus_reset_event, core_wr, line_oe, waitrequest;
   logic usb_irq, resume_irq, phy_power_down, usb_clk_enable, disconnect;
   logic [13:0] address;
   logic [31:0] writedata, readdata;
   logic [3:0] byteenable, in_ep_event, out_ep_event;
   logic [8:0] core_addr;
   logic [7:0] core_wdata, eid;
   logic [1:0] dma_done, dma_req, mode;
   logic [9:0] ev, en;
   logic [10:0] v;
   logic [2:0] sel;
   logic [11:0] ctl;
   logic [15:0] rnd = 16'h5526;
   usr_pins_t line_in, line_out;
   logic [31:0] expq[$];
   int n_errors = 0;
   int checked = 0;
   int cyc = 0;
   int i, k, c;

   usr_core #(.SUSPEND_CNT(SUS), .WAKE_CNT(WK)) DUT (
      .clock(clock), .rst_b(rst_b), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .line_in(line_in), .line_out(line_out), .line_oe(line_oe), .pll_lock(pll_lock),
      .in_ep_event(in_ep_event), .out_ep_event(out_ep_event), .sof_event(sof_event),
      .bus_reset_event(bus_reset_event), .core_wr(core_wr), .core_addr(core_addr), .core_wdata(core_wdata),
      .dma_done(dma_done), .dma_req(dma_req), .usb_irq(usb_irq), .resume_irq(resume_irq),
      .phy_power_down(phy_power_down), .usb_clk_enable(usb_clk_enable), .disconnect(disconnect)
   );
   usr_host_model host (
      .clock(clock), .rst_b(rst_b), .mode(mode), .line_out(line_out), .line_oe(line_oe), .line_in(line_in)
   );

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // buffer fill pattern, distinct over the bytes of one buffer
   function automatic logic [7:0] bdat(input logic [8:0] a);
      return a[7:0] ^ {a[8], 7'h35};
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clock);
   endtask
   // one avalon cycle: hold everything until waitrequest is seen low
   task automatic acc(input logic [11:0] idx, input logic w, input logic [7:0] d);
      @(posedge clock);
      address <= {idx, 2'b00};
      read <= ~w;
      write <= w;
      writedata <= {24'h000000, d};
      @(posedge clock);
      while (waitrequest !== 1'b0) @(posedge clock);
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] idx, input logic [7:0] d);
      acc(idx, 1'b1, d);
   endtask
   task automatic rd(input logic [11:0] idx, input logic [7:0] e);
      expq.push_back({24'h000000, e});
      acc(idx, 1'b0, 8'h00);
   endtask
   task automatic sw(input logic [6:0] sa, input logic [7:0] d);
      wr(IDX_SUB_ADDR, {1'b0, sa});
      wr(IDX_SUB_DATA, d);
   endtask
   task automatic sr(input logic [6:0] sa, input logic [7:0] e);
      wr(IDX_SUB_ADDR, {1'b0, sa});
      rd(IDX_SUB_DATA, e);
   endtask
   task automatic wres(input logic e, input int n);
      for (int j = 0; j < n && resume_irq !== e; j++) @(posedge clock);
   endtask

   // clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // hang guard
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_errors++;
         complete_run();
      end
   end
   // read monitor: oldest expectation against data at the accepting edge
   always @(posedge clock) begin
      if (rst_b && read && !waitrequest) begin
         if (expq.size() == 0) chk("unexpected read", 32'h1, 32'h0);
         else chk("readdata", readdata, expq.pop_front());
      end
   end

   initial begin
      {read, write, pll_lock, sof_event, bus_reset_event, core_wr, rst_b} = 7'h00;
      {address, writedata, core_addr, core_wdata, in_ep_event, out_ep_event, dma_done} = '0;
      byteenable = 4'hF;
      mode = 2'd2;
      wt(2);
      chk("reset outs", {usb_irq, resume_irq, dma_req, line_oe, phy_power_down, usb_clk_enable}, 7'h01);
      rst_b <= 1'b1;
      rd(12'hF5B, 8'h00);
      // random sources and enables: merged request and priority id
      for (i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         ev = rnd[9:0];
         rnd = lfsr(rnd);
         en = rnd[9:0];
         sw(SUB_IN_EN, {4'h0, en[9:6]});
         sw(SUB_OUT_EN, {4'h0, en[5:2]});
         sw(SUB_PROTO_EN, {5'h00, en[1:0], 1'b0});
         @(posedge clock);
         {in_ep_event, out_ep_event, bus_reset_event, sof_event} <= ev;
         @(posedge clock);
         {in_ep_event, out_ep_event, bus_reset_event, sof_event} <= 10'h000;
         v = {ev & en, 1'b0};
         eid = 8'h00;
         for (k = 10; k >= 0; k--) if (v[k]) eid = 8'(k + 1);
         wt(2);
         chk("usb_irq", usb_irq, |v);
         sr(SUB_IID, eid);
         sr(SUB_IN_REQ, {4'h0, ev[9:6]});
         sw(SUB_IN_REQ, 8'hFF);
         sw(SUB_OUT_REQ, 8'hFF);
         sw(SUB_PROTO_REQ, 8'h07);
         @(posedge clock);
         chk("usb_irq cleared", usb_irq, 1'b0);
      end
      // suspend, gate, host resume, pll seen; resume enable off then on
      for (i = 0; i < 2; i++) begin
         pll_lock <= 1'b0;
         wr(IDX_IRQ_CTL, {7'h00, i[0]});
         sw(SUB_PROTO_EN, 8'h01);
         mode <= 2'd0;
         wt(SUS - 10);
         chk("early suspend", usb_irq, 1'b0);
         wt(20);
         chk("suspend irq", usb_irq, 1'b1);
         sr(SUB_PROTO_REQ, 8'h01);
         sw(SUB_PROTO_REQ, 8'h01);
         sw(SUB_CLK_GATE, rnd[7:0]);
         wt(2);
         chk("gated", {phy_power_down, usb_clk_enable}, 2'b10);
         mode <= 2'd1;
         wres(1'b1, 10);
         chk("host resume irq", resume_irq, 1'b1);
         chk("general irq apart", usb_irq, 1'b0);
         wt(50);
         mode <= 2'd2;
         wr(IDX_IRQ_CTL, {5'h00, 2'b10, i[0]});
         wt(2);
         chk("resume cleared", resume_irq, 1'b0);
         pll_lock <= 1'b1;
         wt(8);
         chk("pll resume irq", resume_irq, i[0]);
         chk("clock back", usb_clk_enable, 1'b1);
         sr(SUB_CTRL_STAT, 8'h00);
         wr(IDX_IRQ_CTL, 8'h04);
      end
      // device timed wake from suspend
      mode <= 2'd0;
      wt(SUS + 15);
      sw(SUB_PROTO_REQ, 8'h01);
      sw(SUB_CLK_GATE, 8'h00);
      mode <= 2'd2;
      wr(IDX_IRQ_CTL, 8'h03);
      sr(SUB_CTRL_STAT, 8'h04);
      mode <= 2'd0;
      wt(WK - 10);
      chk("wake early", resume_irq, 1'b0);
      wres(1'b1, 30);
      chk("wake irq", resume_irq, 1'b1);
      rd(IDX_IRQ_CTL, 8'h05);
      // software timed wake with enable clear; line drive
      wr(IDX_IRQ_CTL, 8'h04);
      wt(WK + 5);
      wr(IDX_IRQ_CTL, 8'h02);
      sw(SUB_CTRL_STAT, 8'h02);
      wt(1);
      chk("force j", {line_oe, line_out}, 3'b110);
      sw(SUB_CTRL_STAT, 8'h01);
      wt(1);
      chk("resume k", {line_oe, line_out}, 3'b101);
      wt(WK + 10);
      chk("no device irq", resume_irq, 1'b0);
      sw(SUB_CTRL_STAT, 8'h08);
      wt(1);
      chk("released", {line_oe, disconnect}, 2'b01);
      sw(SUB_CTRL_STAT, 8'h00);
      wr(IDX_IRQ_CTL, 8'h00);
      // fill every endpoint buffer from the engine side
      for (k = 0; k < 512; k++) begin
         @(posedge clock);
         core_wr <= 1'b1;
         core_addr <= 9'(k);
         core_wdata <= bdat(9'(k));
      end
      @(posedge clock);
      core_wr <= 1'b0;
      rd(IDX_DMA_DATA, 8'h00);
      // each channel: launch, partial run, relaunch from zero, full run, end
      for (c = 0; c < 2; c++) begin
         rnd = lfsr(rnd);
         sel = rnd[2:0];
         ctl = c ? IDX_DMA1_CTL : IDX_DMA0_CTL;
         wr(ctl, {5'h01, sel});
         @(posedge clock);
         chk("dma_req up", dma_req, c ? 2'b10 : 2'b01);
         rd(ctl, {5'h10, sel});
         for (k = 0; k < 5; k++) rd(IDX_DMA_DATA, bdat({sel, 6'(k)}));
         wr(ctl, {5'h01, sel});
         for (k = 0; k < 64; k++) rd(IDX_DMA_DATA, bdat({sel, 6'(k)}));
         chk("dma_req held", dma_req[c], 1'b1);
         if (c == 0) begin
            wr(IDX_DMA_DATA, 8'h00);
         end else begin
            @(posedge clock);
            dma_done <= 2'b10;
            @(posedge clock);
            dma_done <= 2'b00;
         end
         wt(1);
         chk("dma_req down", dma_req, 2'b00);
      end
      // a data port write lands at byte 0 and reads back after a relaunch
      wr(IDX_DMA0_CTL, {5'h01, sel});
      wr(IDX_DMA_DATA, 8'hA5);
      wr(IDX_DMA0_CTL, {5'h01, sel});
      rd(IDX_DMA_DATA, 8'hA5);
      complete_run();
   end
endmodule
